// ### hw/iie_top.sv
// Isolated input event processor: eight inputs, filters, pattern match,
// change of state and event counters behind a plain register port.
// Assumes inputs synchronous to sys_clk_i and a 40 MHz clock.
`timescale 1ns/1ps
module iie_top #(
  parameter int NCH = iie_pkg::NCH
) (
  input  wire logic           sys_clk_i,
  input  wire logic           rstn_i,
  input  wire logic [NCH-1:0] input_i,
  input  wire iie_pkg::iie_bus_t bus_i,
  output logic [15:0]         rdata_o,
  output logic                irq_o
);
  // Tick dividers
  logic [11:0] fast_div;
  logic [5:0]  slow_div;
  logic        fast_tick;
  logic        slow_tick;

  // Configuration
  logic [NCH-1:0] filt_en;
  logic [NCH-1:0] pat_en;
  logic [NCH-1:0] pat_val;
  logic [NCH-1:0] cos_en;
  logic [NCH-1:0] cos_rise;
  logic [NCH-1:0] cos_fall;
  logic [NCH-1:0] cnt_en;
  logic [NCH-1:0] cnt_fall;
  logic [NCH-1:0] match_ie;
  logic [NCH-1:0] ovf_ie;
  logic           irq_enable;
  logic [15:0]    hi_cnt [NCH];
  logic [15:0]    lo_cnt [NCH];
  logic [15:0]    reload [NCH];
  logic [15:0]    match_val [NCH];
  logic [15:0]    count [NCH];

  // State
  logic [NCH-1:0] level;
  logic [NCH-1:0] level_d;
  logic [NCH-1:0] snapshot;
  logic           pat_hit;
  logic           pat_hit_d;
  logic [3:0]     evt;
  logic [3:0]     evt_set;
  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic [NCH-1:0] cnt_step;
  logic [NCH-1:0] match_ev;
  logic [NCH-1:0] ovf_ev;
  logic           wr_evt;

  // Per-channel register decode
  function automatic logic sel(input logic [7:0] a, input logic [7:0] base,
                               input int ch);
    return a == (base + 8'(ch));
  endfunction

  // 100 us enable from 40 MHz, 5 ms enable from the 100 us one
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fast_div <= 12'h000;
    end else if (fast_tick) begin
      fast_div <= 12'h000;
    end else begin
      fast_div <= fast_div + 12'h001;
    end
  end
  assign fast_tick = (fast_div == 12'(iie_pkg::FAST_TICK_CYC - 1));

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slow_div <= 6'h00;
    end else if (fast_tick) begin
      slow_div <= slow_tick ? 6'h00 : slow_div + 6'h01;
    end
  end
  assign slow_tick = fast_tick && (slow_div == 6'(iie_pkg::SLOW_TICK_FAST - 1));

  // Filter per channel
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    iie_filter u_filt (
      .sys_clk_i   (sys_clk_i),
      .rstn_i      (rstn_i),
      .fast_tick_i (fast_tick),
      .slow_tick_i (slow_tick),
      .filt_en_i   (filt_en[c]),
      .raw_i       (input_i[c]),
      .hi_cnt_i    (hi_cnt[c]),
      .lo_cnt_i    (lo_cnt[c]),
      .level_o     (level[c])
    );
  end

  // Snapshot of raw inputs every 100 us
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      snapshot <= '0;
    end else if (fast_tick) begin
      snapshot <= input_i;
    end
  end

  // Edge detection on accepted levels
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_d   <= '0;
      pat_hit_d <= 1'b0;
    end else begin
      level_d   <= level;
      pat_hit_d <= pat_hit;
    end
  end
  assign rise = level & ~level_d;
  assign fall = ~level & level_d;

  // Pattern compare over enabled channels only
  assign pat_hit = (|pat_en) && (((level ^ pat_val) & pat_en) == '0);

  // Counter edge selection, chosen per channel
  assign cnt_step = cnt_en & ((cnt_fall & fall) | (~cnt_fall & rise));

  // Event counters
  for (genvar c = 0; c < NCH; c++) begin : g_cnt
    assign ovf_ev[c]   = cnt_step[c] && (count[c] == iie_pkg::CNT_MAX);
    assign match_ev[c] = cnt_step[c] && !ovf_ev[c]
                         && (count[c] + 16'h0001 == match_val[c]);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        count[c] <= 16'h0000;
      end else if (bus_i.wr && sel(bus_i.addr, iie_pkg::REG_RELOAD, c)) begin
        count[c] <= bus_i.wdata;
      end else if (!cnt_en[c]) begin
        count[c] <= reload[c];
      end else if (ovf_ev[c]) begin
        count[c] <= reload[c];
      end else if (cnt_step[c]) begin
        count[c] <= count[c] + 16'h0001;
      end
    end
  end

  // Sticky event flags; set wins over software clear
  assign evt_set[iie_pkg::EVT_PAT]   = pat_hit && !pat_hit_d;
  assign evt_set[iie_pkg::EVT_COS]   = |(cos_en & ((rise & cos_rise)
                                       | (fall & cos_fall)));
  assign evt_set[iie_pkg::EVT_MATCH] = |(match_ev & match_ie);
  assign evt_set[iie_pkg::EVT_OVF]   = |(ovf_ev & ovf_ie);
  assign wr_evt = bus_i.wr && bus_i.addr == iie_pkg::REG_EVT_FLAGS;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      evt <= 4'h0;
    end else begin
      evt <= (wr_evt ? (evt & ~bus_i.wdata[3:0]) : evt) | evt_set;
    end
  end

  // Interrupt output gated by the single enable
  assign irq_o = irq_enable && (|evt);

  // Filter enables, one bit per channel
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      filt_en <= '0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_FILT_EN) begin
      filt_en <= bus_i.wdata[NCH-1:0];
    end
  end

  // Channels taking part in the pattern compare
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pat_en <= '0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_PAT_EN) begin
      pat_en <= bus_i.wdata[NCH-1:0];
    end
  end

  // Levels the pattern compare looks for
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pat_val <= '0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_PAT_VAL) begin
      pat_val <= bus_i.wdata[NCH-1:0];
    end
  end

  // Channels that may raise a change event
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cos_en <= '0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_COS_EN) begin
      cos_en <= bus_i.wdata[NCH-1:0];
    end
  end

  // Rising edges count as a change
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cos_rise <= '0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_COS_RISE) begin
      cos_rise <= bus_i.wdata[NCH-1:0];
    end
  end

  // Falling edges count as a change
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cos_fall <= '0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_COS_FALL) begin
      cos_fall <= bus_i.wdata[NCH-1:0];
    end
  end

  // Counter enables; a disabled counter sits at its reload
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_en <= '0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_CNT_EN) begin
      cnt_en <= bus_i.wdata[NCH-1:0];
    end
  end

  // Counter edge, set for falling
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_fall <= '0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_CNT_FALL) begin
      cnt_fall <= bus_i.wdata[NCH-1:0];
    end
  end

  // Counter match event enables
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      match_ie <= '0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_MATCH_IE) begin
      match_ie <= bus_i.wdata[NCH-1:0];
    end
  end

  // Counter overflow event enables
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovf_ie <= '0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_OVF_IE) begin
      ovf_ie <= bus_i.wdata[NCH-1:0];
    end
  end

  // Single host interrupt enable
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_enable <= 1'b0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_IRQ_ENABLE) begin
      irq_enable <= bus_i.wdata[iie_pkg::IRQ_EN_BIT];
    end
  end

  // Per-channel value writes; filter counts clamp to at least 2
  for (genvar c = 0; c < NCH; c++) begin : g_cfg
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        hi_cnt[c]    <= iie_pkg::FILT_CNT_RESET;
        lo_cnt[c]    <= iie_pkg::FILT_CNT_RESET;
        reload[c]    <= 16'h0000;
        match_val[c] <= 16'h0000;
      end else if (bus_i.wr) begin
        if (sel(bus_i.addr, iie_pkg::REG_HI_CNT, c)) begin
          hi_cnt[c] <= (bus_i.wdata < 16'h0002) ? 16'h0002 : bus_i.wdata;
        end
        if (sel(bus_i.addr, iie_pkg::REG_LO_CNT, c)) begin
          lo_cnt[c] <= (bus_i.wdata < 16'h0002) ? 16'h0002 : bus_i.wdata;
        end
        if (sel(bus_i.addr, iie_pkg::REG_RELOAD, c)) begin
          reload[c] <= bus_i.wdata;
        end
        if (sel(bus_i.addr, iie_pkg::REG_MATCH, c)) begin
          match_val[c] <= bus_i.wdata;
        end
      end
    end
  end

  // Read mux, registered one cycle after the strobe
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    unique case (bus_i.addr)
      iie_pkg::REG_FILT_EN:    next_rdata[NCH-1:0] = filt_en;
      iie_pkg::REG_PAT_EN:     next_rdata[NCH-1:0] = pat_en;
      iie_pkg::REG_PAT_VAL:    next_rdata[NCH-1:0] = pat_val;
      iie_pkg::REG_COS_EN:     next_rdata[NCH-1:0] = cos_en;
      iie_pkg::REG_COS_RISE:   next_rdata[NCH-1:0] = cos_rise;
      iie_pkg::REG_COS_FALL:   next_rdata[NCH-1:0] = cos_fall;
      iie_pkg::REG_CNT_EN:     next_rdata[NCH-1:0] = cnt_en;
      iie_pkg::REG_CNT_FALL:   next_rdata[NCH-1:0] = cnt_fall;
      iie_pkg::REG_MATCH_IE:   next_rdata[NCH-1:0] = match_ie;
      iie_pkg::REG_OVF_IE:     next_rdata[NCH-1:0] = ovf_ie;
      iie_pkg::REG_IRQ_ENABLE: next_rdata[iie_pkg::IRQ_EN_BIT] = irq_enable;
      iie_pkg::REG_IRQ_STATUS: begin
        next_rdata[iie_pkg::IRQ_ST_BIT] = |evt;
        next_rdata[iie_pkg::IRQ_AS_BIT] = irq_o;
      end
      iie_pkg::REG_SNAPSHOT:   next_rdata[NCH-1:0] = snapshot;
      iie_pkg::REG_LEVEL:      next_rdata[NCH-1:0] = level;
      iie_pkg::REG_EVT_FLAGS:  next_rdata[3:0] = evt;
      default: begin
        for (int c = 0; c < NCH; c++) begin
          if (sel(bus_i.addr, iie_pkg::REG_HI_CNT, c)) next_rdata = hi_cnt[c];
          if (sel(bus_i.addr, iie_pkg::REG_LO_CNT, c)) next_rdata = lo_cnt[c];
          if (sel(bus_i.addr, iie_pkg::REG_RELOAD, c)) next_rdata = reload[c];
          if (sel(bus_i.addr, iie_pkg::REG_MATCH, c))  next_rdata = match_val[c];
          if (sel(bus_i.addr, iie_pkg::REG_COUNT, c))  next_rdata = count[c];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= bus_i.rd ? next_rdata : 16'h0000;
    end
  end
endmodule

// ### pkg/iie_pkg.sv
// Package for the isolated input event processor.
// Assumes a 40 MHz system clock; register port is a plain strobe bus.
package iie_pkg;
  localparam int CLK_HZ          = 40_000_000;
  localparam int FAST_TICK_US    = 100;
  localparam int SLOW_TICK_MS    = 5;
  localparam int FAST_TICK_CYC   = CLK_HZ / 1_000_000 * FAST_TICK_US;
  localparam int SLOW_TICK_FAST  = SLOW_TICK_MS * 1000 / FAST_TICK_US;
  localparam int NCH             = 8;
  localparam logic [15:0] CNT_MAX        = 16'hffff;
  localparam logic [15:0] FILT_CNT_RESET = 16'h0002;

  // Register offsets (word index on the 8-bit address port)
  localparam logic [7:0] REG_FILT_EN    = 8'h00;
  localparam logic [7:0] REG_PAT_EN     = 8'h01;
  localparam logic [7:0] REG_PAT_VAL    = 8'h02;
  localparam logic [7:0] REG_COS_EN     = 8'h03;
  localparam logic [7:0] REG_COS_RISE   = 8'h04;
  localparam logic [7:0] REG_COS_FALL   = 8'h05;
  localparam logic [7:0] REG_CNT_EN     = 8'h06;
  localparam logic [7:0] REG_CNT_FALL   = 8'h07;
  localparam logic [7:0] REG_MATCH_IE   = 8'h08;
  localparam logic [7:0] REG_OVF_IE     = 8'h09;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h0a;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h0b;
  localparam logic [7:0] REG_SNAPSHOT   = 8'h0c;
  localparam logic [7:0] REG_LEVEL      = 8'h0d;
  localparam logic [7:0] REG_EVT_FLAGS  = 8'h0e;
  // Per-channel blocks: base + channel
  localparam logic [7:0] REG_HI_CNT     = 8'h10;
  localparam logic [7:0] REG_LO_CNT     = 8'h18;
  localparam logic [7:0] REG_RELOAD     = 8'h20;
  localparam logic [7:0] REG_MATCH      = 8'h28;
  localparam logic [7:0] REG_COUNT      = 8'h30;

  // Bit positions
  localparam int IRQ_EN_BIT  = 5;
  localparam int IRQ_ST_BIT  = 6;
  localparam int IRQ_AS_BIT  = 7;
  localparam int EVT_PAT     = 0;
  localparam int EVT_COS     = 1;
  localparam int EVT_MATCH   = 2;
  localparam int EVT_OVF     = 3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } iie_bus_t;
endpackage

// ### hw/iie_filter.sv
// Debounce filter for one isolated input channel.
// Assumes input synchronous to sys_clk_i; ticks are one-cycle enables.
`timescale 1ns/1ps
module iie_filter (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        fast_tick_i,
  input  wire logic        slow_tick_i,
  input  wire logic        filt_en_i,
  input  wire logic        raw_i,
  input  wire logic [15:0] hi_cnt_i,
  input  wire logic [15:0] lo_cnt_i,
  output logic             level_o
);
  logic [15:0] run;
  logic [15:0] thresh;

  // Threshold by direction of the pending change
  assign thresh = level_o ? lo_cnt_i : hi_cnt_i;

  // Accepted level and run of differing samples
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      level_o <= 1'b0;
      run     <= 16'h0000;
    end else if (!filt_en_i) begin
      run <= 16'h0000;
      if (fast_tick_i) begin
        level_o <= raw_i;
      end
    end else if (slow_tick_i) begin
      if (raw_i == level_o) begin
        run <= 16'h0000;
      end else if (run + 16'h0001 >= thresh) begin
        level_o <= raw_i;
        run     <= 16'h0000;
      end else begin
        run <= run + 16'h0001;
      end
    end
  end
endmodule

// ### bench/iie_chk.sv
// Checker for the input event processor: register port and interrupt line.
// Assumes it sees only the top-level ports; bound at the foot of this file.
`timescale 1ns/1ps
module iie_chk #(
  parameter int NCH = iie_pkg::NCH
) (
  input wire logic              sys_clk_i,
  input wire logic              rstn_i,
  input wire logic [NCH-1:0]    input_i,
  input wire iie_pkg::iie_bus_t bus_i,
  input wire logic [15:0]       rdata_o,
  input wire logic              irq_o
);
  logic           en_sh;
  logic [NCH-1:0] filt_sh;
  logic [15:0]    calm;
  logic           rd_st;
  logic           rd_snap;
  logic           rd_lvl;
  logic           rd_evt;
  logic           rd_cnt;
  logic           wr_clr;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // Decoded host accesses
  assign rd_st   = bus_i.rd && bus_i.addr == iie_pkg::REG_IRQ_STATUS;
  assign rd_snap = bus_i.rd && bus_i.addr == iie_pkg::REG_SNAPSHOT;
  assign rd_lvl  = bus_i.rd && bus_i.addr == iie_pkg::REG_LEVEL;
  assign rd_evt  = bus_i.rd && bus_i.addr == iie_pkg::REG_EVT_FLAGS;
  assign rd_cnt  = bus_i.rd && bus_i.addr[7:4] == 4'h1;
  assign wr_clr  = bus_i.wr && bus_i.addr == iie_pkg::REG_EVT_FLAGS && bus_i.wdata[3:0] == 4'hf;

  // Shadow of host-written enables
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_sh <= 1'b0;
      filt_sh <= '0;
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_IRQ_ENABLE) begin
      en_sh <= bus_i.wdata[iie_pkg::IRQ_EN_BIT];
    end else if (bus_i.wr && bus_i.addr == iie_pkg::REG_FILT_EN) begin
      filt_sh <= bus_i.wdata[NCH-1:0];
    end
  end

  // Cycles the inputs have been still; past one tick the snapshot and unfiltered levels are settled
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      calm <= 16'h0000;
    end else if (input_i != $past(input_i)) begin
      calm <= 16'h0000;
    end else if (calm != 16'hffff) begin
      calm <= calm + 16'h0001;
    end
  end

  read_quiet_a: assert property (!$past(bus_i.rd) |-> rdata_o == 16'h0000)
    else $error("read data not idle");
  irq_gate_a: assert property (!en_sh |-> !irq_o)
    else $error("interrupt without enable");
  status_irq_a: assert property (rd_st |=> rdata_o[7] == $past(irq_o) && (!rdata_o[7] || rdata_o[6]))
    else $error("status bits disagree with interrupt");
  snap_follow_a: assert property (rd_snap && calm > 16'd4006 |=> rdata_o == 16'($past(input_i)))
    else $error("snapshot stale");
  level_follow_a: assert property (rd_lvl && filt_sh == '0 && calm > 16'd4006
    |=> rdata_o == 16'($past(input_i)))
    else $error("unfiltered level stale");
  filt_floor_a: assert property (rd_cnt |=> rdata_o >= 16'h0002)
    else $error("sample count below two");
  evt_width_a: assert property (rd_evt |=> rdata_o[15:4] == 12'h000)
    else $error("event flags wider than four");
  irq_clear_a: assert property (wr_clr && calm > 16'd4006 |=> !irq_o)
    else $error("interrupt stays after clear");

  cover property ($rose(irq_o));
  cover property (rd_st ##1 rdata_o[7]);
  cover property (wr_clr && irq_o);
endmodule

bind iie_top iie_chk #(.NCH(NCH)) i_iie_chk (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .input_i(input_i), .bus_i(bus_i), .rdata_o(rdata_o), .irq_o(irq_o));

// ### bench/iie_field.sv
// Field contact model: drives the isolated inputs from a commanded level.
// Assumes the bench commands levels; contacts settle one clock later.
`timescale 1ns/1ps
module iie_field (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] level_i,
  output wire logic [7:0] contact_o
);
  logic [7:0] held = 8'h00;

  // Contacts take the commanded level at the next edge
  always @(posedge sys_clk_i) begin
    held <= level_i;
  end
  assign contact_o = held;
endmodule

// ### bench/iie_top_test.sv
// Testbench for the input event processor: register tasks and field stimulus.
// Assumes a 40 MHz clock and the field contact model beside the block.
`timescale 1ns/1ps
module iie_top_test;
  logic              sys_clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic [7:0]        level = 8'h00;
  logic [7:0]        input_i;
  iie_pkg::iie_bus_t bus_i = '0;
  logic [15:0]       rdata_o;
  logic              irq_o;
  logic [15:0]       rd_val;
  int                fails = 0;
  int                n_compared = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;

  iie_top i_iie_top (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .input_i(input_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .irq_o(irq_o));
  iie_field i_iie_field (.sys_clk_i(sys_clk_i), .level_i(level), .contact_o(input_i));

  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    bus_i.wr <= 1'b1;
    bus_i.addr <= a;
    bus_i.wdata <= d;
    @(posedge sys_clk_i);
    bus_i.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    bus_i.rd <= 1'b1;
    bus_i.addr <= a;
    @(posedge sys_clk_i);
    bus_i.rd <= 1'b0;
    #1 rd_val = rdata_o;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    rd(a);
    check(rd_val, exp);
  endtask
  // New contact levels, then one full sample tick
  task automatic drive(input logic [7:0] v);
    @(posedge sys_clk_i);
    level <= v;
    repeat (iie_pkg::FAST_TICK_CYC + 12) @(posedge sys_clk_i);
  endtask
  task automatic complete_run;
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog of twenty-five ticks, above the seventeen drive ticks plus register traffic
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    fails++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    // Reset values, unmapped place and count clamp
    for (int c = 0; c < 8; c++) begin
      rchk(iie_pkg::REG_HI_CNT + 8'(c), 16'h0002);
      rchk(iie_pkg::REG_LO_CNT + 8'(c), 16'h0002);
      rchk(iie_pkg::REG_COUNT + 8'(c), 16'h0000);
    end
    rchk(8'hff, 16'h0000);
    wr(iie_pkg::REG_HI_CNT, 16'h0001);
    rchk(iie_pkg::REG_HI_CNT, 16'h0002);
    wr(iie_pkg::REG_LO_CNT + 8'h07, 16'hffff);
    rchk(iie_pkg::REG_LO_CNT + 8'h07, 16'hffff);
    rchk(iie_pkg::REG_HI_CNT + 8'h07, 16'h0002);
    // Unfiltered inputs reach level and snapshot
    drive(8'h30);
    rchk(iie_pkg::REG_LEVEL, 16'h0030);
    rchk(iie_pkg::REG_SNAPSHOT, 16'h0030);
    rchk(iie_pkg::REG_EVT_FLAGS, 16'h0000);
    // Change of state in rise, fall and both modes
    wr(iie_pkg::REG_COS_EN, 16'h0001);
    for (int m = 1; m < 4; m++) begin
      wr(iie_pkg::REG_COS_RISE, 16'(m & 1));
      wr(iie_pkg::REG_COS_FALL, 16'(m >> 1));
      wr(iie_pkg::REG_EVT_FLAGS, 16'h000f);
      drive(8'h31);
      rchk(iie_pkg::REG_EVT_FLAGS, 16'(m & 1) << 1);
      wr(iie_pkg::REG_EVT_FLAGS, 16'h000f);
      drive(8'h30);
      rchk(iie_pkg::REG_EVT_FLAGS, 16'(m >> 1) << 1);
    end
    check(16'(irq_o), 16'h0000);
    rchk(iie_pkg::REG_IRQ_STATUS, 16'h0040);
    wr(iie_pkg::REG_IRQ_ENABLE, 16'h0020);
    #1 check(16'(irq_o), 16'h0001);
    rchk(iie_pkg::REG_IRQ_STATUS, 16'h00c0);
    wr(iie_pkg::REG_EVT_FLAGS, 16'h000f);
    #1 check(16'(irq_o), 16'h0000);
    drive(8'h32);
    rchk(iie_pkg::REG_EVT_FLAGS, 16'h0000);
    // Counters: ch2 rising from reload near the top, ch3 falling from zero
    wr(iie_pkg::REG_CNT_FALL, 16'h0008);
    wr(iie_pkg::REG_RELOAD + 8'h02, 16'hfffd);
    rchk(iie_pkg::REG_COUNT + 8'h02, 16'hfffd);
    wr(iie_pkg::REG_MATCH + 8'h02, 16'hfffe);
    wr(iie_pkg::REG_MATCH_IE, 16'h0004);
    wr(iie_pkg::REG_OVF_IE, 16'h0004);
    wr(iie_pkg::REG_CNT_EN, 16'h000c);
    wr(iie_pkg::REG_EVT_FLAGS, 16'h000f);
    drive(8'h3e);
    rchk(iie_pkg::REG_COUNT + 8'h02, 16'hfffe);
    rchk(iie_pkg::REG_COUNT + 8'h03, 16'h0000);
    rchk(iie_pkg::REG_EVT_FLAGS, 16'h0004);
    wr(iie_pkg::REG_EVT_FLAGS, 16'h000f);
    drive(8'h32);
    rchk(iie_pkg::REG_COUNT + 8'h03, 16'h0001);
    drive(8'h3e);
    rchk(iie_pkg::REG_COUNT + 8'h02, 16'hffff);
    rchk(iie_pkg::REG_EVT_FLAGS, 16'h0000);
    drive(8'h32);
    drive(8'h3e);
    rchk(iie_pkg::REG_COUNT + 8'h02, 16'hfffd);
    rchk(iie_pkg::REG_EVT_FLAGS, 16'h0008);
    // Pattern on ch7,6,2,1 with don't-care channels moving
    wr(iie_pkg::REG_CNT_EN, 16'h0000);
    wr(iie_pkg::REG_PAT_EN, 16'h00c6);
    wr(iie_pkg::REG_PAT_VAL, 16'h0086);
    wr(iie_pkg::REG_EVT_FLAGS, 16'h000f);
    drive(8'h82);
    rchk(iie_pkg::REG_EVT_FLAGS, 16'h0000);
    drive(8'h86);
    rchk(iie_pkg::REG_EVT_FLAGS, 16'h0001);
    wr(iie_pkg::REG_EVT_FLAGS, 16'h000f);
    drive(8'hb6);
    rchk(iie_pkg::REG_EVT_FLAGS, 16'h0000);
    // Filtered ch0 holds its level through a fast tick; snapshot stays raw
    wr(iie_pkg::REG_FILT_EN, 16'h0001);
    drive(8'hb7);
    rchk(iie_pkg::REG_LEVEL, 16'h00b6);
    rchk(iie_pkg::REG_SNAPSHOT, 16'h00b7);
    complete_run();
  end
endmodule
